// File: verilog/tx_nibble_payload_input.sv
`default_nettype none

module tx_nibble_payload_input (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Configuration and reference pins
    input wire logic i_nibble_iface_select,
    input wire logic i_rx_line_clock_in,
    input wire logic i_tx_ref_clock_in,
    input wire logic i_tx_frame_reference_in,
    // Terminal nibble interface
    input wire logic [3:0] i_tx_nibble_data_in,
    output logic o_tx_nibble_clock_out,
    output logic o_tx_last_nibble_pulse,
    output logic o_tx_overhead_indicator,
    output logic o_rx_recovered_clock_out,
    // Towards the transmit framer
    output logic [3:0] o_payload_nibble,
    output logic o_payload_valid,
    output logic o_frame_start,
    output logic o_local_loopback_en
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] sync_level;
    logic [7:0] sync_rise;
    logic nib_sel;
    logic rx_rise;
    logic tx_rise;
    logic fref_rise;
    logic [3:0] nib_data;
    logic [7:0] mode_ctrl_reg;
    tx_nibble_pkg::timing_mode_e mode;
    logic nibble_mode;
    logic lb_refused;
    logic [8:0] pos_reg;
    logic [8:0] pos_next;
    logic [15:0] frames_reg;
    logic [3:0] last_capture_reg;
    logic setup;
    logic access_wr;
    logic [31:0] status_word;
    logic [31:0] capture_word;
    logic [9:0] rise_cnt_reg;
    logic frame_seen_reg;

    nibble_timing_if tim ();

    // ****************************************
    // Pin synchronisers and divider
    // ****************************************

    // All pins share one filter; data bits only use the level
    pin_sync #(
        .WIDTH(8)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin({i_nibble_iface_select, i_rx_line_clock_in,
                i_tx_ref_clock_in, i_tx_frame_reference_in,
                i_tx_nibble_data_in}),
        .o_level(sync_level),
        .o_rise(sync_rise)
    );

    assign nib_sel = sync_level[7];
    assign rx_rise = sync_rise[6];
    assign tx_rise = sync_rise[5];
    assign fref_rise = sync_rise[4];
    assign nib_data = sync_level[3:0];

    nibble_divider u_div (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .tim(tim)
    );

    // ****************************************
    // Mode decode
    // ****************************************

    // select pin and timing field pick the mode
    always_comb begin
        if (!nib_sel) begin
            mode = tx_nibble_pkg::mode_serial;
        end else if (mode_ctrl_reg[tx_nibble_pkg::TIMREF_MSB:
                                   tx_nibble_pkg::TIMREF_LSB]
                     == tx_nibble_pkg::TIMREF_LOOP) begin
            mode = tx_nibble_pkg::mode_loop_nibble;
        end else if (mode_ctrl_reg[tx_nibble_pkg::TIMREF_MSB:
                                   tx_nibble_pkg::TIMREF_LSB]
                     == tx_nibble_pkg::TIMREF_LOCAL) begin
            mode = tx_nibble_pkg::mode_slave_nibble;
        end else begin
            mode = tx_nibble_pkg::mode_idle;
        end
    end

    assign nibble_mode = (mode == tx_nibble_pkg::mode_loop_nibble) ||
                         (mode == tx_nibble_pkg::mode_slave_nibble);

    // loop-timed takes the receive line clock
    assign tim.ref_tick = (mode == tx_nibble_pkg::mode_loop_nibble) ?
                          rx_rise : tx_rise;

    // divided clock reaches the pin in nibble modes only
    assign o_tx_nibble_clock_out = tim.nib_clk & nibble_mode;

    // Recovered receive clock is the filtered line clock level
    assign o_rx_recovered_clock_out = sync_level[6];

    // Loop-back request is blocked while loop-timed, and flagged
    assign lb_refused = mode_ctrl_reg[tx_nibble_pkg::LOOPBACK_BIT] &&
                        (mode == tx_nibble_pkg::mode_loop_nibble);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_local_loopback_en <= 1'b0;
        end else begin
            o_local_loopback_en <=
                mode_ctrl_reg[tx_nibble_pkg::LOOPBACK_BIT] && !lb_refused;
        end
    end

    // ****************************************
    // Nibble position within the frame
    // ****************************************

    // in frame-slave mode, a frame reference edge restarts the frame
    always_comb begin
        if (mode == tx_nibble_pkg::mode_slave_nibble && fref_rise) begin
            pos_next = 9'h000;
        end else if (tim.nib_rise) begin
            pos_next = (pos_reg == tx_nibble_pkg::LAST_NIBBLE) ?
                       9'h000 : pos_reg + 9'h001;
        end else begin
            pos_next = pos_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pos_reg <= tx_nibble_pkg::POS_RESET;
            frames_reg <= 16'h0000;
            o_frame_start <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            o_frame_start <= nibble_mode && (pos_next == 9'h000) &&
                             (pos_reg != 9'h000);
            if (pos_next == 9'h000 && pos_reg != 9'h000) begin
                frames_reg <= frames_reg + 16'h0001;
            end
        end
    end

    // ****************************************
    // Frame markers towards the terminal
    // ****************************************

    // last-nibble pulse, loop-timed mode only, for the whole last nibble period
    // overhead window spans three nibble periods
    // window opens one nibble ahead of the alignment nibble
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_tx_last_nibble_pulse <= 1'b0;
            o_tx_overhead_indicator <= 1'b0;
        end else begin
            o_tx_last_nibble_pulse <=
                (mode == tx_nibble_pkg::mode_loop_nibble) &&
                (pos_next == tx_nibble_pkg::LAST_NIBBLE);
            o_tx_overhead_indicator <= nibble_mode &&
                ((pos_next == tx_nibble_pkg::LAST_NIBBLE) ||
                 (pos_next < tx_nibble_pkg::OH_NIBBLES - 9'h001));
        end
    end

    // ****************************************
    // Payload capture
    // ****************************************

    // capture the nibble on the sampling tick
    // overhead nibbles are not passed on, terminal data dropped
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_payload_nibble <= 4'h0;
            o_payload_valid <= 1'b0;
            last_capture_reg <= 4'h0;
        end else begin
            o_payload_valid <= 1'b0;
            if (tim.sample && nibble_mode) begin
                last_capture_reg <= nib_data;
                if (pos_reg >= tx_nibble_pkg::OH_NIBBLES) begin
                    o_payload_nibble <= nib_data;
                    o_payload_valid <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // APB register file
    // ****************************************
    assign setup = i_psel && !i_penable;
    assign access_wr = i_psel && i_penable && i_pwrite;

    // Status word shows position and decoded mode
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[tx_nibble_pkg::STAT_POS_LSB +: 9] = pos_reg;
        status_word[tx_nibble_pkg::STAT_NIBBLE_BIT] = nibble_mode;
        status_word[tx_nibble_pkg::STAT_LOOP_BIT] =
            (mode == tx_nibble_pkg::mode_loop_nibble);
        status_word[tx_nibble_pkg::STAT_SLAVE_BIT] =
            (mode == tx_nibble_pkg::mode_slave_nibble);
        status_word[tx_nibble_pkg::STAT_LB_REFUSED_BIT] = lb_refused;
        capture_word = 32'h0000_0000;
        capture_word[3:0] = last_capture_reg;
        capture_word[tx_nibble_pkg::CAP_FRAMES_LSB +: 16] = frames_reg;
    end

    // Zero wait states, so the access phase always completes
    assign o_pready = 1'b1;

    // Read data and error are latched in setup, ready for access
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
            unique case (i_paddr)
                tx_nibble_pkg::ADDR_MODE_CTRL: begin
                    o_prdata <= {24'h00_0000, mode_ctrl_reg};
                end
                tx_nibble_pkg::ADDR_STATUS: begin
                    o_prdata <= status_word;
                    o_pslverr <= i_pwrite;
                end
                tx_nibble_pkg::ADDR_CAPTURE: begin
                    o_prdata <= capture_word;
                    o_pslverr <= i_pwrite;
                end
                default: begin
                    o_pslverr <= 1'b1;
                end
            endcase
        end
    end

    // Mode control write takes effect at the access edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_ctrl_reg <= tx_nibble_pkg::MODE_CTRL_RESET;
        end else if (access_wr &&
                     i_paddr == tx_nibble_pkg::ADDR_MODE_CTRL) begin
            mode_ctrl_reg <= i_pwdata[7:0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // Helper count of nibble edges between frame pulses
    always_ff @(posedge i_clk) begin
        if (i_reset || mode != tx_nibble_pkg::mode_loop_nibble) begin
            rise_cnt_reg <= 10'h000;
            frame_seen_reg <= 1'b0;
        end else if ($rose(o_tx_last_nibble_pulse)) begin
            rise_cnt_reg <= 10'h000;
            frame_seen_reg <= 1'b1;
        end else if (tim.nib_rise) begin
            rise_cnt_reg <= rise_cnt_reg + 10'h001;
        end
    end

    a_frame_length: assert property (
        $rose(o_tx_last_nibble_pulse) && frame_seen_reg &&
        mode == tx_nibble_pkg::mode_loop_nibble |->
            rise_cnt_reg == tx_nibble_pkg::FRAME_NIBBLES)
        else $error("frame pulses not 384 nibbles apart");

    a_last_one_period: assert property (
        $changed(o_tx_last_nibble_pulse) && $past(mode, 2) == mode &&
        mode == tx_nibble_pkg::mode_loop_nibble |-> $past(tim.nib_rise))
        else $error("last-nibble pulse moved off a nibble edge");

    a_loop_ref_source: assert property (
        mode == tx_nibble_pkg::mode_loop_nibble |->
            tim.ref_tick == rx_rise)
        else $error("loop-timed mode not on receive clock");

    a_slave_ref_source: assert property (
        mode == tx_nibble_pkg::mode_slave_nibble |->
            tim.ref_tick == tx_rise)
        else $error("frame-slave mode not on transmit clock");

    a_overhead_start: assert property (
        $rose(o_tx_overhead_indicator) && !$past(fref_rise) &&
        $past(mode, 2) == mode |-> pos_reg == tx_nibble_pkg::LAST_NIBBLE)
        else $error("overhead window opened at wrong nibble");

    a_overhead_close: assert property (
        o_tx_overhead_indicator && pos_reg == 9'h001 && tim.nib_rise &&
        !fref_rise |=> !o_tx_overhead_indicator)
        else $error("overhead window longer than three nibbles");

    a_frame_ref_restart: assert property (
        mode == tx_nibble_pkg::mode_slave_nibble && fref_rise |=>
            pos_reg == 9'h000 && (o_frame_start || $past(pos_reg) == 9'h000))
        else $error("frame reference did not restart frame");

    a_capture_data: assert property (
        tim.sample && nibble_mode &&
        pos_reg >= tx_nibble_pkg::OH_NIBBLES |=>
            o_payload_valid && o_payload_nibble == $past(nib_data))
        else $error("nibble not captured on sampling tick");

    a_payload_only: assert property (
        o_payload_valid |-> $past(pos_reg) >= tx_nibble_pkg::OH_NIBBLES)
        else $error("overhead nibble passed on as payload");

    a_loopback_block: assert property (
        lb_refused |=> !o_local_loopback_en)
        else $error("loop-back enabled in loop-timed mode");

endmodule

`default_nettype wire

// File: verilog/tx_nibble_pkg.sv
`default_nettype none

package tx_nibble_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] ADDR_MODE_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CAPTURE = 12'h008;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h28;
    localparam int LOOPBACK_BIT = 7;
    localparam int TIMREF_LSB = 0;
    localparam int TIMREF_MSB = 1;
    localparam logic [1:0] TIMREF_LOOP = 2'h0;
    localparam logic [1:0] TIMREF_LOCAL = 2'h1;

    // Status and capture field positions
    localparam int STAT_POS_LSB = 0;
    localparam int STAT_NIBBLE_BIT = 9;
    localparam int STAT_LOOP_BIT = 10;
    localparam int STAT_SLAVE_BIT = 11;
    localparam int STAT_LB_REFUSED_BIT = 12;
    localparam int CAP_FRAMES_LSB = 16;

    // ****************************************
    // Frame and divider geometry
    // ****************************************
    localparam int FRAME_BITS = 1536;
    localparam int NIBBLE_BITS = 4;
    localparam logic [9:0] FRAME_NIBBLES = 10'h180;
    localparam logic [8:0] LAST_NIBBLE = 9'h17F;
    localparam logic [8:0] OH_NIBBLES = 9'h003;
    localparam logic [8:0] POS_RESET = 9'h17F;
    localparam logic [1:0] PHASE_RISE = 2'h3;
    localparam logic [1:0] PHASE_SAMPLE = 2'h2;
    localparam logic [1:0] PHASE_CLK_LOW = 2'h2;
    localparam logic [2:0] TICKS_PER_NIBBLE = 3'h4;
    localparam logic [2:0] TICKS_TO_SAMPLE = 3'h2;

    // Transmit timing modes
    typedef enum logic [1:0] {
        mode_idle,
        mode_serial,
        mode_loop_nibble,
        mode_slave_nibble
    } timing_mode_e;

endpackage

`default_nettype wire

// File: verilog/nibble_timing_if.sv
`default_nettype none

// ****************************************
// Nibble timing between divider and framer
// ****************************************
interface nibble_timing_if;
    logic ref_tick;
    logic nib_clk;
    logic nib_rise;
    logic sample;

    modport gen (input ref_tick, output nib_clk, output nib_rise,
                 output sample);
    modport user (output ref_tick, input nib_clk, input nib_rise,
                  input sample);
endinterface

`default_nettype wire

// File: verilog/pin_sync.sv
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] i_pin,
    // Filtered level and rising-edge pulse
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // ****************************************
    // Three-stage capture, change once 2 and 3 agree
    // ****************************************
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        // Stage one is read by stage two only
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                s1_reg[b] <= 1'b0;
                s2_reg[b] <= 1'b0;
                s3_reg[b] <= 1'b0;
                o_level[b] <= 1'b0;
            end else begin
                s1_reg[b] <= i_pin[b];
                s2_reg[b] <= s1_reg[b];
                s3_reg[b] <= s2_reg[b];
                if (s2_reg[b] == s3_reg[b]) begin
                    o_level[b] <= s3_reg[b];
                end
            end
        end

        // Pulse in the cycle before the filtered level turns high
        assign o_rise[b] = (s2_reg[b] == s3_reg[b]) & s3_reg[b] &
                           ~o_level[b];
    end

endmodule

`default_nettype wire

// File: verilog/nibble_divider.sv
`default_nettype none

module nibble_divider (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Timing towards the framer
    nibble_timing_if.gen tim
);

    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic [2:0] tick_cnt_reg;
    logic seen_reg;

    localparam logic [1:0] PHASE_CLK_LOW_L = tx_nibble_pkg::PHASE_CLK_LOW;

    // ****************************************
    // Divide-by-four of the reference ticks
    // ****************************************

    // free-running divider
    // Never restarted by mode or frame, so nibble edges stay put
    assign phase_next = phase_reg + 2'h1;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_reg <= 2'h0;
            tim.nib_clk <= 1'b0;
        end else if (tim.ref_tick) begin
            phase_reg <= phase_next;
            tim.nib_clk <= (phase_next < PHASE_CLK_LOW_L);
        end
    end

    // Rise marks the nibble edge, sample the third tick after it
    assign tim.nib_rise = tim.ref_tick &
                          (phase_reg == tx_nibble_pkg::PHASE_RISE);
    assign tim.sample = tim.ref_tick &
                        (phase_reg == tx_nibble_pkg::PHASE_SAMPLE);

    // Helper count of ticks since the last nibble edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tick_cnt_reg <= 3'h0;
            seen_reg <= 1'b0;
        end else if (tim.nib_rise) begin
            tick_cnt_reg <= 3'h0;
            seen_reg <= 1'b1;
        end else if (tim.ref_tick && tick_cnt_reg != 3'h7) begin
            tick_cnt_reg <= tick_cnt_reg + 3'h1;
        end
    end

    a_nibble_div_ratio: assert property (
        @(posedge i_clk) disable iff (i_reset)
        tim.nib_rise && seen_reg |->
            tick_cnt_reg == tx_nibble_pkg::TICKS_PER_NIBBLE - 3'h1)
        else $error("nibble edge not four ticks after previous");

    a_sample_third_tick: assert property (
        @(posedge i_clk) disable iff (i_reset)
        tim.sample && seen_reg |->
            tick_cnt_reg == tx_nibble_pkg::TICKS_TO_SAMPLE)
        else $error("sample not on third tick after nibble edge");

endmodule

`default_nettype wire

// File: tb/terminal_nibble_source.sv
`default_nettype none

module terminal_nibble_source (
    // Clock
    input wire logic i_clk,
    // From the framer and the reference
    input wire logic i_nibble_clock,
    input wire logic i_frame_marker,
    input wire logic i_ref_clock,
    input wire logic i_send_ref,
    // Towards the framer
    output logic [3:0] o_payload,
    output logic o_frame_ref
);
    timeunit 1ns;
    timeprecision 1ns;

    logic nib_q = 1'b0;
    logic ref_q = 1'b0;
    logic marked = 1'b0;
    logic pending = 1'b0;
    logic fref = 1'b0;
    logic [3:0] nib = 4'h0;

    assign o_payload = nib;
    assign o_frame_ref = fref;

    // Edge history of the clocks we follow
    always_ff @(posedge i_clk) begin
        nib_q <= i_nibble_clock;
        ref_q <= i_ref_clock;
    end

    always_ff @(posedge i_clk) begin
        if (i_nibble_clock && !nib_q) begin
            nib <= marked ? 4'h0 : nib + 4'h1;
            marked <= 1'b0;
        end
        if (i_frame_marker) begin
            marked <= 1'b1;
        end
    end

    // one reference period, rise to rise
    always_ff @(posedge i_clk) begin
        if (i_ref_clock && !ref_q) begin
            fref <= pending;
            pending <= 1'b0;
        end
        // Request set last so a coinciding edge cannot lose it
        if (i_send_ref) begin
            pending <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// File: tb/e3_tx_nibble_payload_input_tb_top.sv
`default_nettype none

module e3_tx_nibble_payload_input_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic nib_sel = 1'b0;
    logic rx_clk = 1'b0;
    logic tx_clk = 1'b0;
    logic send_ref = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, nib_clk, last_nib, oh_ind;
    logic frame_ref, pvalid, fstart, lb_en, rx_rec;
    logic [3:0] tdata, pnib;
    logic [5:0] mon;
    logic [5:0] prev = 6'h00;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int nib_cnt = 0;
    int val_cnt = 0;
    int n, a, b;

    assign mon = {rx_rec, frame_ref, fstart, oh_ind, last_nib, nib_clk};

    tx_nibble_payload_input tx_nibble_payload_input_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_nibble_iface_select(nib_sel),
        .i_rx_line_clock_in(rx_clk), .i_tx_ref_clock_in(tx_clk),
        .i_tx_frame_reference_in(frame_ref), .i_tx_nibble_data_in(tdata),
        .o_tx_nibble_clock_out(nib_clk), .o_tx_last_nibble_pulse(last_nib),
        .o_tx_overhead_indicator(oh_ind), .o_rx_recovered_clock_out(rx_rec),
        .o_payload_nibble(pnib), .o_payload_valid(pvalid),
        .o_frame_start(fstart), .o_local_loopback_en(lb_en));

    terminal_nibble_source terminal_nibble_source_i (
        .i_clk(i_clk), .i_nibble_clock(nib_clk), .i_frame_marker(last_nib),
        .i_ref_clock(tx_clk), .i_send_ref(send_ref), .o_payload(tdata),
        .o_frame_ref(frame_ref));

    // ****************************************
    // Clocks, counters, payload monitor
    // ****************************************
    initial begin
        forever #50 i_clk = ~i_clk;
    end

    // Receive reference 8 cycles a period, transmit 10, so the
    // nibble period shows which reference is in use
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles % 4 == 3) rx_clk <= ~rx_clk;
        if (cycles % 5 == 4) tx_clk <= ~tx_clk;
        prev <= mon;
        if (mon[0] && !prev[0]) nib_cnt <= nib_cnt + 1;
        if (pvalid === 1'b1) begin
            val_cnt <= val_cnt + 1;
            chk("payload", tdata, pnib);
        end
        if (cycles == 60000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles until the next low-to-high of one monitored signal
    task automatic next_rise(input int i, output int cnt);
        logic p;
        cnt = 0;
        p = 1'b1;
        while (cnt < 30000) begin
            @(posedge i_clk);
            cnt++;
            if (mon[i] === 1'b1 && p === 1'b0) break;
            p = mon[i];
        end
        if (cnt >= 30000) bad_count++;
    endtask

    task automatic high_len(input int i, output int cnt);
        cnt = 0;
        while (mon[i] === 1'b1 && cnt < 30000) begin
            @(posedge i_clk);
            cnt++;
        end
        if (cnt >= 30000) bad_count++;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        apb(1'b0, tx_nibble_pkg::ADDR_MODE_CTRL, 32'h0000_0000);
        chk("ctrl reset", tx_nibble_pkg::MODE_CTRL_RESET, rd);
        apb(1'b1, tx_nibble_pkg::ADDR_STATUS, 32'h0000_0001);
        chk("ro write err", 1, err);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {rd[30:0], err});
        // Loop-timed nibble mode with loop-back requested
        nib_sel <= 1'b1;
        apb(1'b1, tx_nibble_pkg::ADDR_MODE_CTRL, 32'h0000_0080);
        apb(1'b0, tx_nibble_pkg::ADDR_MODE_CTRL, 32'h0000_0000);
        chk("ctrl back", 32'h0000_0080, rd);
        apb(1'b0, tx_nibble_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status", 4'hB, rd[12:9]);
        chk("loopback", 0, lb_en);
        next_rise(0, n);
        next_rise(0, n);
        chk("loop nib period", 32, n);
        next_rise(5, n);
        next_rise(5, n);
        chk("rx clock out", 8, n);
        next_rise(1, n);
        a = nib_cnt;
        b = val_cnt;
        chk("oh rise", 2'b01, {prev[2], mon[2]});
        high_len(1, n);
        chk("last width", 32, n);
        next_rise(1, n);
        chk("nibbles", 384, nib_cnt - a);
        chk("payloads", 381, val_cnt - b);
        high_len(2, n);
        chk("oh width", 96, n);
        // Frame-slave nibble mode, loop-back now allowed
        apb(1'b1, tx_nibble_pkg::ADDR_MODE_CTRL, 32'h0000_0081);
        repeat (2) @(posedge i_clk);
        chk("loopback", 1, lb_en);
        next_rise(0, n);
        next_rise(0, n);
        chk("slave nib period", 40, n);
        send_ref <= 1'b1;
        @(posedge i_clk);
        send_ref <= 1'b0;
        next_rise(4, n);
        next_rise(3, n);
        chk("ref to start", 1, n <= 8);
        // Reserved timing field: no nibble mode decoded
        apb(1'b1, tx_nibble_pkg::ADDR_MODE_CTRL, 32'h0000_0002);
        apb(1'b0, tx_nibble_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("idle status", 4'h0, rd[12:9]);
        // Serial mode: no nibble clock at all
        nib_sel <= 1'b0;
        repeat (16) @(posedge i_clk);
        a = nib_cnt;
        repeat (100) @(posedge i_clk);
        chk("serial nib clk", 0, nib_cnt - a);
        apb(1'b0, tx_nibble_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status", 4'h0, rd[12:9]);
        tally_and_finish;
    end
endmodule

`default_nettype wire
